// ===== inc/sr_blank_defines.svh
`ifndef SR_BLANK_DEFINES_SVH
`define SR_BLANK_DEFINES_SVH

// Clock period in picoseconds (125 MHz)
`define CLK_PERIOD_PS       32'd8000
// Absolute floors of the blanking durations, in picoseconds
`define MIN_TON_FLOOR_PS    32'd55000
`define MIN_TOFF_FLOOR_PS   32'd70000
// Floors in cycles, rounded up
`define MIN_TON_FLOOR_CYC   ((`MIN_TON_FLOOR_PS + `CLK_PERIOD_PS - 32'd1) / `CLK_PERIOD_PS)
`define MIN_TOFF_FLOOR_CYC  ((`MIN_TOFF_FLOOR_PS + `CLK_PERIOD_PS - 32'd1) / `CLK_PERIOD_PS)
// Default configured durations in cycles, and the default exception multiple
`define DEF_TON_CYC         16'h0019
`define DEF_TOFF_CYC        16'h0032
`define DEF_EXC_MULT        8'h04
`define TIMER_ZERO          16'h0000
`define TIMER_ONE           16'h0001

`endif

// ===== inc/sr_blank_pkg.sv
package sr_blank_pkg;

    typedef enum logic [2:0] {
        ST_ARM_WAIT,
        ST_OFF_BLANK,
        ST_READY,
        ST_ON_BLANK,
        ST_ON,
        ST_EXC_BLANK
    } sr_state_t;

    typedef struct packed {
        logic below_on;
        logic above_off;
        logic above_rearm;
        logic fast_slope;
    } sense_t;

endpackage : sr_blank_pkg

// ===== rtl/sr_blank_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "sr_blank_defines.svh"

module sr_blank_ctrl
    import sr_blank_pkg::*;
#(
    parameter bit        FIXED_TIMING = 1'b1,
    parameter bit [15:0] FIXED_TON    = `DEF_TON_CYC,
    parameter bit [15:0] FIXED_TOFF   = `DEF_TOFF_CYC,
    parameter bit [7:0]  FIXED_EXC    = `DEF_EXC_MULT
) (
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    input  wire logic        below_on_i,
    input  wire logic        above_off_i,
    input  wire logic        above_rearm_i,
    input  wire logic        fast_slope_detect_i,
    input  wire logic        fast_slope_en_i,
    input  wire logic        exception_en_i,
    input  wire logic [15:0] ton_cycles_i,
    input  wire logic [15:0] toff_cycles_i,
    input  wire logic [7:0]  exception_mult_i,
    output logic             gate_drive_output_o,
    output logic             exception_running_o
);

    localparam logic [15:0] TON_FLOOR  = 16'(`MIN_TON_FLOOR_CYC);
    localparam logic [15:0] TOFF_FLOOR = 16'(`MIN_TOFF_FLOOR_CYC);

    // Pin inputs pass a two-stage synchroniser; only the second stage is read
    sense_t      sense_meta;
    sense_t      sense;
    logic [1:0]  opt_meta;
    logic [1:0]  opt;
    logic [15:0] ton_meta;
    logic [15:0] ton_sync;
    logic [15:0] toff_meta;
    logic [15:0] toff_sync;
    logic [7:0]  mult_meta;
    logic [7:0]  mult_sync;

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            sense_meta <= '0;
            sense      <= '0;
        end else begin
            sense_meta <= '{below_on_i, above_off_i, above_rearm_i, fast_slope_detect_i};
            sense      <= sense_meta;
        end
    end

    // Options come up disabled so a reset never starts with a shortcut armed
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            opt_meta <= 2'h0;
            opt      <= 2'h0;
        end else begin
            opt_meta <= {exception_en_i, fast_slope_en_i};
            opt      <= opt_meta;
        end
    end

    // Setting words are sampled bit by bit; a change mid-word can give one
    // odd value for a cycle, which the floors below still bound
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ton_meta <= `DEF_TON_CYC;
            ton_sync <= `DEF_TON_CYC;
        end else begin
            ton_meta <= ton_cycles_i;
            ton_sync <= ton_meta;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            toff_meta <= `DEF_TOFF_CYC;
            toff_sync <= `DEF_TOFF_CYC;
        end else begin
            toff_meta <= toff_cycles_i;
            toff_sync <= toff_meta;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            mult_meta <= `DEF_EXC_MULT;
            mult_sync <= `DEF_EXC_MULT;
        end else begin
            mult_meta <= exception_mult_i;
            mult_sync <= mult_meta;
        end
    end

    function automatic logic [15:0] clamp_floor(input logic [15:0] v, input logic [15:0] f);
        clamp_floor = (v < f) ? f : v;
    endfunction : clamp_floor

    // Shared by both timers so they count and stop at zero the same way
    function automatic logic [15:0] count_down(input logic [15:0] v);
        count_down = (v == `TIMER_ZERO) ? `TIMER_ZERO : v - `TIMER_ONE;
    endfunction : count_down

    // Duration selection: fixed variants ignore the setting inputs entirely
    wire logic [15:0] ton_raw;
    wire logic [15:0] toff_raw;
    wire logic [7:0]  mult_raw;
    wire logic [15:0] ton_len;
    wire logic [15:0] toff_len;
    wire logic [7:0]  mult_eff;
    wire logic [23:0] exc_prod;
    wire logic [15:0] exc_len;

    assign ton_raw  = FIXED_TIMING ? FIXED_TON  : ton_sync;
    assign toff_raw = FIXED_TIMING ? FIXED_TOFF : toff_sync;
    assign mult_raw = FIXED_TIMING ? FIXED_EXC  : mult_sync;
    assign ton_len  = clamp_floor(ton_raw, TON_FLOOR);
    assign toff_len = clamp_floor(toff_raw, TOFF_FLOOR);
    assign mult_eff = (mult_raw == 8'h00) ? 8'h01 : mult_raw;
    // Saturates instead of wrapping so a large multiple cannot yield a short window
    assign exc_prod = ton_len * mult_eff;
    assign exc_len  = (exc_prod[23:16] != 8'h00) ? 16'hFFFF : exc_prod[15:0];

    // Exception wins when both are requested; slope option is then forced off
    wire logic exc_on;
    wire logic slope_on;

    assign exc_on   = opt[1];
    assign slope_on = opt[0] && !opt[1];

    sr_state_t   state;
    sr_state_t   next_state;
    logic [15:0] blank_cnt;
    logic [15:0] next_blank_cnt;
    logic [15:0] exc_cnt;
    logic [15:0] next_exc_cnt;
    logic        rearm_prev;
    logic        gate;
    logic        next_gate;

    wire logic        blank_done;
    wire logic        exc_running;
    wire logic        rearm_cross;
    wire logic [15:0] blank_dec;
    wire logic [15:0] exc_dec;

    assign blank_done  = (blank_cnt == `TIMER_ZERO);
    assign exc_running = (exc_cnt != `TIMER_ZERO);
    // Either direction counts: rising and falling crossings both restart the off blank,
    // so a ring that only grazes the threshold still stretches the blank
    assign rearm_cross = sense.above_rearm != rearm_prev;
    assign blank_dec   = count_down(blank_cnt);
    assign exc_dec     = count_down(exc_cnt);

    always_comb begin
        next_state     = state;
        next_blank_cnt = blank_dec;
        next_exc_cnt   = exc_dec;
        next_gate      = gate;
        case (state)
            ST_ARM_WAIT: begin
                next_gate = 1'b0;
                if (sense.above_rearm) begin
                    next_state     = ST_OFF_BLANK;
                    next_blank_cnt = toff_len;
                end
            end
            ST_OFF_BLANK: begin
                if (!sense.above_rearm && !slope_on) begin
                    // Sense dropped: the off period must start over
                    next_state     = ST_ARM_WAIT;
                end else if (rearm_cross) begin
                    next_blank_cnt = toff_len;
                end
                if (slope_on && sense.fast_slope) begin
                    next_state     = ST_READY;
                    next_blank_cnt = `TIMER_ZERO;
                end else if (blank_done && sense.above_rearm) begin
                    next_state = ST_READY;
                end
            end
            ST_READY: begin
                if (sense.below_on) begin
                    next_state     = ST_ON_BLANK;
                    next_gate      = 1'b1;
                    next_blank_cnt = ton_len;
                    next_exc_cnt   = exc_on ? exc_len : `TIMER_ZERO;
                end
            end
            ST_ON_BLANK: begin
                // Turn-off comparator is not looked at here
                if (blank_done) begin
                    next_state = ST_ON;
                end
            end
            ST_ON: begin
                if (sense.above_off) begin
                    next_gate = 1'b0;
                    if (exc_on && exc_running) begin
                        next_state     = ST_EXC_BLANK;
                        next_blank_cnt = ton_len;
                    end else begin
                        next_state = ST_ARM_WAIT;
                    end
                end
            end
            ST_EXC_BLANK: begin
                // Turn-on comparator masked to avoid rapid on/off cycling
                if (blank_done) begin
                    if (sense.below_on && exc_running) begin
                        next_state     = ST_ON_BLANK;
                        next_gate      = 1'b1;
                        next_blank_cnt = ton_len;
                    end else begin
                        next_state = ST_ARM_WAIT;
                    end
                end
            end
            default: begin
                next_state = ST_ARM_WAIT;
                next_gate  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            state <= ST_ARM_WAIT;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            blank_cnt <= `TIMER_ZERO;
        end else begin
            blank_cnt <= next_blank_cnt;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            exc_cnt <= `TIMER_ZERO;
        end else begin
            exc_cnt <= next_exc_cnt;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            rearm_prev <= 1'b0;
        end else begin
            rearm_prev <= sense.above_rearm;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            gate <= 1'b0;
        end else begin
            gate <= next_gate;
        end
    end

    // Output registers load the next values so the pins line up with the state;
    // this costs a duplicate flip-flop but keeps the pins glitch free
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            gate_drive_output_o <= 1'b0;
        end else begin
            gate_drive_output_o <= next_gate;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            exception_running_o <= 1'b0;
        end else begin
            exception_running_o <= (next_exc_cnt != `TIMER_ZERO);
        end
    end

endmodule : sr_blank_ctrl

`default_nettype wire

// ===== tb/sr_blank_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sr_blank_chk
    import sr_blank_pkg::*;
#(
    parameter bit [15:0] FIXED_TON = 16'h0019
) (
    input  wire logic clk_sys_i,
    input  wire logic resetn_i,
    input  wire logic below_on_i,
    input  wire logic above_off_i,
    input  wire logic gate_drive_output_o,
    input  wire logic exception_running_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    rst_gate_a: assert property (@(posedge clk_sys_i) disable iff (1'b0)
        !resetn_i |=> !gate_drive_output_o) else $error("gate high after reset");
    rst_exc_a: assert property (@(posedge clk_sys_i) disable iff (1'b0)
        !resetn_i |=> !exception_running_o) else $error("timer busy after reset");
    start_low_a: assert property (
        $rose(resetn_i) |-> !gate_drive_output_o [*8]) else $error("early gate at start");
    on_min_a: assert property (
        $rose(gate_drive_output_o) |-> gate_drive_output_o [*7]) else $error("on blank short");
    off_min_a: assert property (
        $fell(gate_drive_output_o) |-> !gate_drive_output_o [*7]) else $error("off too short");
    on_cause_a: assert property (
        $rose(gate_drive_output_o) |-> $past(below_on_i, 3)) else $error("gate on uncaused");
    off_cause_a: assert property (
        $fell(gate_drive_output_o) |-> $past(above_off_i, 3)) else $error("gate off uncaused");
    exc_start_a: assert property (
        $rose(exception_running_o) |-> $rose(gate_drive_output_o)) else $error("timer start");
    cover property ($rose(gate_drive_output_o));
    cover property ($fell(gate_drive_output_o) && exception_running_o);
    cover property ($fell(exception_running_o));
endmodule : sr_blank_chk
bind sr_blank_ctrl sr_blank_chk #(.FIXED_TON(FIXED_TON)) i_sr_blank_chk (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .below_on_i(below_on_i),
    .above_off_i(above_off_i), .gate_drive_output_o(gate_drive_output_o),
    .exception_running_o(exception_running_o));
`default_nettype wire

// ===== tb/sr_sense_model.sv
`timescale 1ns/1ps
`default_nettype none
module sr_sense_model
    import sr_blank_pkg::*;
(
    input  wire logic [1:0] level_i,
    input  wire logic       slope_i,
    output wire sense_t     sense_o
);
    // Level 0 conducting, 1 near zero current, 2 blocking
    assign sense_o = '{below_on: level_i == 2'h0, above_off: level_i != 2'h0,
                       above_rearm: level_i == 2'h2, fast_slope: slope_i};
endmodule : sr_sense_model
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sr_blank_pkg::*;
    logic        clk_sys_i = 1'b0, resetn_i = 1'b0, slope = 1'b0, fs_en = 1'b0, exc_en = 1'b0;
    logic        gate, exc_run, gate_fix;
    logic [1:0]  level = 2'h2;
    logic [15:0] ton = 16'h0000, toff = 16'h0000;
    logic [7:0]  mult = 8'h04;
    sense_t      sense;
    int          bad_count = 0, checks = 0, cyc_n = 0, n = 0;
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, a); end end
    always #4 clk_sys_i = ~clk_sys_i;
    sr_sense_model i_sr_sense_model (.level_i(level), .slope_i(slope), .sense_o(sense));
    sr_blank_ctrl #(.FIXED_TIMING(1'b0)) i_sr_blank_ctrl (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .below_on_i(sense.below_on),
        .above_off_i(sense.above_off), .above_rearm_i(sense.above_rearm),
        .fast_slope_detect_i(sense.fast_slope), .fast_slope_en_i(fs_en),
        .exception_en_i(exc_en), .ton_cycles_i(ton), .toff_cycles_i(toff),
        .exception_mult_i(mult), .gate_drive_output_o(gate), .exception_running_o(exc_run));
    // Built-in durations: must ignore the setting inputs shared with the other instance
    sr_blank_ctrl i_sr_blank_ctrl_fixed (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .below_on_i(sense.below_on),
        .above_off_i(sense.above_off), .above_rearm_i(sense.above_rearm),
        .fast_slope_detect_i(sense.fast_slope), .fast_slope_en_i(fs_en),
        .exception_en_i(exc_en), .ton_cycles_i(ton), .toff_cycles_i(toff),
        .exception_mult_i(mult), .gate_drive_output_o(gate_fix), .exception_running_o());
    task tick(input int k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask : tick
    task wait_gate(input logic v, input int lim);
        n = 0;
        while (gate !== v && n < lim) begin
            tick(1);
            n++;
        end
    endtask : wait_gate
    task restart(input logic f, input logic e, input logic [15:0] on, input logic [15:0] off);
        resetn_i = 1'b0;
        fs_en = f;
        exc_en = e;
        ton = on;
        toff = off;
        level = 2'h2;
        tick(16);
        resetn_i = 1'b1;
    endtask : restart
    task t_ringing;
        restart(1'b0, 1'b0, 16'h0000, 16'h0014);
        repeat (5) begin
            tick(13);
            level = 2'h0;
            tick(2);
            level = 2'h2;
            tick(2);
            `CHK("gate in ringing", 1'b0, gate)
        end
        tick(30);
        level = 2'h0;
        wait_gate(1'b1, 8);
        `CHK("gate after blank", 1'b1, gate)
    endtask : t_ringing
    task t_floors;
        restart(1'b0, 1'b0, 16'h0000, 16'h0000);
        tick(5);
        level = 2'h0;
        wait_gate(1'b1, 8);
        `CHK("gate off floor", 1'b0, gate)
        level = 2'h2;
        tick(14);
        level = 2'h0;
        wait_gate(1'b1, 8);
        `CHK("gate on", 1'b1, gate)
        `CHK("fixed off blank", 1'b0, gate_fix)
        level = 2'h1;
        wait_gate(1'b0, 16);
        `CHK("on floor", 1'b1, n >= 6 && n <= 12)
    endtask : t_floors
    task t_exception;
        restart(1'b0, 1'b1, 16'h000A, 16'h000A);
        tick(14);
        level = 2'h0;
        wait_gate(1'b1, 8);
        `CHK("timer start", 1'b1, exc_run)
        level = 2'h1;
        wait_gate(1'b0, 16);
        `CHK("off after blank", 1'b1, n >= 9)
        level = 2'h0;
        wait_gate(1'b1, 20);
        `CHK("re-on delay", 1'b1, n >= 9 && gate === 1'b1)
        `CHK("timer running", 1'b1, exc_run)
        tick(40);
        `CHK("timer expired", 1'b0, exc_run)
        level = 2'h1;
        wait_gate(1'b0, 8);
        level = 2'h0;
        wait_gate(1'b1, 20);
        `CHK("no re-on", 1'b0, gate)
    endtask : t_exception
    task t_slope(input logic e, input logic v);
        restart(1'b1, e, 16'h0000, 16'h00C8);
        tick(20);
        slope = 1'b1;
        tick(2);
        slope = 1'b0;
        level = 2'h0;
        wait_gate(1'b1, 10);
        `CHK("slope shortcut", v, gate)
    endtask : t_slope
    task test_done;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done
    // Whole run needs under a thousand cycles
    always @(posedge clk_sys_i) begin
        cyc_n++;
        if (cyc_n == 5000) begin
            bad_count++;
            test_done();
        end
    end
    initial begin
        t_ringing();
        t_floors();
        t_exception();
        t_slope(1'b0, 1'b1);
        t_slope(1'b1, 1'b0);
        test_done();
    end
endmodule : tb
`default_nettype wire
